/* File: rcr_pkg.sv */
// rms configuration and output trigger register bank: shared constants and types
// assumes a 32-bit apb slave with one aligned word per register index
package rcr_pkg;

  // ====================
  // register indices (byte address is four times the index)
  // ====================
  localparam logic [7:0] IDX_CH7_HIGH   = 8'hAF; // last channel 7 result, msb byte
  localparam logic [7:0] IDX_RMS_CONFIG    = 8'hC0; // rms configuration
  localparam logic [7:0] IDX_RMS_LOW    = 8'hC1; // rms result low byte
  localparam logic [7:0] IDX_RMS_HIGH   = 8'hC2; // rms result high byte
  localparam logic [7:0] IDX_OUT0_MASK  = 8'hC3; // general output 0 trigger mask
  localparam logic [7:0] IDX_OUT1_MASK  = 8'hC5; // general output 1 trigger mask
  localparam logic [7:0] IDX_OUT2_MASK  = 8'hC7; // general output 2 trigger mask
  localparam logic [7:0] IDX_OUT3_MASK  = 8'hC9; // general output 3 trigger mask
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0; // sticky event status, read clears
  localparam logic [7:0] IDX_IRQ_MASK   = 8'hE1; // interrupt enable mask

  // ====================
  // reset values
  // ====================
  localparam logic [7:0]  RST_RMS_CONFIG   = 8'h00;
  localparam logic [15:0] RST_RMS_VALUE = 16'h0000;
  localparam logic [7:0]  RST_OUT0_MASK = 8'h02;
  localparam logic [7:0]  RST_OUT1_MASK = 8'h01;
  localparam logic [7:0]  RST_OUT2_MASK = 8'h08;
  localparam logic [7:0]  RST_OUT3_MASK = 8'h04;
  localparam logic [7:0]  RST_CH7_HIGH  = 8'h00;
  localparam logic [7:0]  RST_IRQ_MASK  = 8'h00;
  localparam logic [7:0]  RST_IRQ_STAT  = 8'h00;

  // ====================
  // field positions
  // ====================
  localparam int unsigned CFG_CHAN_LSB = 4;  // channel select, bits 7..4
  localparam int unsigned CFG_DC_BIT   = 2;  // dc removal enable
  localparam int unsigned CFG_SAMP_LSB = 0;  // window sample count, bits 1..0
  localparam int unsigned ST_RMS_DONE  = 0;  // status: rms window completed
  localparam int unsigned ST_CH7_NEW   = 1;  // status: new channel 7 result
  localparam int unsigned ST_OUT_LSB   = 2;  // status: output 0..3 triggered
  localparam int unsigned CONV_MSB_LSB = 4;  // msb-aligned byte of 12-bit result

  // ====================
  // window lengths in samples, and misc
  // ====================
  localparam logic [16:0] WIN_LEN_0 = 17'h00400; // 1024
  localparam logic [16:0] WIN_LEN_1 = 17'h01000; // 4096
  localparam logic [16:0] WIN_LEN_2 = 17'h04000; // 16384
  localparam logic [16:0] WIN_LEN_3 = 17'h10000; // 65536
  localparam logic [3:0]  CH7_ID    = 4'h7;
  localparam int unsigned NUM_OUT   = 4;

  // ====================
  // types
  // ====================
  typedef struct packed {
    logic [3:0] rms_channel_select;  // channel fed to the rms engine
    logic       rsvd;                // always zero
    logic       dc_removal_enable;   // subtract dc from the result
    logic [1:0] window_sample_count; // window length code
  } rcr_cfg_s;

  typedef struct packed {
    logic        valid;  // one-cycle strobe
    logic [3:0]  chan;   // channel of this conversion
    logic [11:0] data;   // conversion result
  } rcr_conv_s;

  // window length in samples from the two-bit code
  function automatic logic [16:0] rcr_win_len(input logic [1:0] code);
    logic [16:0] len;
    len = WIN_LEN_0;
    unique case (code)
      2'b00: len = WIN_LEN_0;
      2'b01: len = WIN_LEN_1;
      2'b10: len = WIN_LEN_2;
      2'b11: len = WIN_LEN_3;
    endcase
    return len;
  endfunction : rcr_win_len

endpackage : rcr_pkg

/* File: rcr_regs.sv */
// rms configuration, rms result and general output trigger mask registers
// assumes apb master on pclk; conversion stream, rms engine and alerts are
// synchronous to pclk and need no synchroniser
//
// Functional notes
// - bits 7..4 select rms input channel
// - bit 2 enables dc removal
// - bits 1..0 pick 1024/4096/16384/65536 samples
// - bit 3 reserved, reads zero
// - 0xC1 reads rms result low byte
// - 0xC2 reads rms result high byte
// - one mask bit per channel pin
// - clear bit blocks that channel's alerts
// - set bit lets alerts trigger output
// - config at 0xC0, resets to zero
// - output 0 mask 0xC3, reset 0x2
// - output 1 mask 0xC5, reset 0x1
// - output 2 mask 0xC7, reset 0x8
// - output 3 mask 0xC9, reset 0x4
// - channel 7 msb-aligned result byte, resets zero
// - channel 7 byte at 0xAF
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps

module rcr_regs (
  input  wire logic              pclk,             // 125 MHz bus clock
  input  wire logic              presetn,          // async reset, active low
  input  wire logic              psel,             // apb select
  input  wire logic              penable,          // apb access phase
  input  wire logic              pwrite,           // apb direction
  input  wire logic [11:0]       paddr,            // apb byte address
  input  wire logic [31:0]       pwdata,           // apb write data
  input  wire logic [3:0]        pstrb,            // apb byte strobes
  output logic      [31:0]       prdata,           // apb read data
  output logic                   pready,           // apb ready
  output logic                   pslverr,          // apb error, unmapped
  input  rcr_pkg::rcr_conv_s     conv_in,          // conversion stream
  input  wire logic [15:0]       rms_engine_value, // running rms estimate
  input  wire logic [7:0]        alert_flags,      // per-channel alert flags
  output rcr_pkg::rcr_cfg_s      rms_config,          // config to rms engine
  output logic                   rms_window_done,  // pulse per window
  output logic [3:0]             out_update,       // general output triggers
  output logic                   irq               // level interrupt
);

  // ====================
  // state
  // ====================
  rcr_pkg::rcr_cfg_s cfg_r;              // rms configuration
  logic [15:0]       rms_value_r;        // latched rms result
  logic [7:0]        mask_r [4];         // trigger masks, outputs 0..3
  logic [7:0]        ch7_high_r;         // channel 7 msb byte
  logic [7:0]        irq_stat_r;         // sticky events
  logic [7:0]        irq_mask_r;         // interrupt enables
  logic [16:0]       win_cnt_r;          // samples in current window
  logic [3:0]        trig_prev_r;        // trigger level last cycle
  logic [31:0]       prdata_r;           // read data
  logic              pready_r;           // ready
  logic              pslverr_r;          // error
  logic              done_r;             // window done pulse
  logic [3:0]        out_update_r;       // trigger pulses
  logic              irq_r;              // interrupt level

  // ====================
  // bus decode
  // ====================
  logic       setup;       // first cycle of a transfer
  logic       acc_done;    // access completes this edge
  logic       wr_en;       // low byte write completes
  logic       rd_done;     // read completes
  logic [7:0] idx;         // register index
  logic       in_range;    // address bits outside index are legal

  assign setup    = psel & ~penable;
  assign acc_done = psel & penable & pready_r;
  assign wr_en    = acc_done & pwrite & pstrb[0];
  assign rd_done  = acc_done & ~pwrite;
  assign idx      = paddr[9:2];
  assign in_range = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);

  // index is one of the mapped registers
  function automatic logic rcr_hit(input logic [7:0] i);
    logic h;
    h = (i == rcr_pkg::IDX_CH7_HIGH)  ||
        (i == rcr_pkg::IDX_RMS_CONFIG)   ||
        (i == rcr_pkg::IDX_RMS_LOW)   ||
        (i == rcr_pkg::IDX_RMS_HIGH)  ||
        (i == rcr_pkg::IDX_OUT0_MASK) ||
        (i == rcr_pkg::IDX_OUT1_MASK) ||
        (i == rcr_pkg::IDX_OUT2_MASK) ||
        (i == rcr_pkg::IDX_OUT3_MASK) ||
        (i == rcr_pkg::IDX_IRQ_STATUS) ||
        (i == rcr_pkg::IDX_IRQ_MASK);
    return h;
  endfunction : rcr_hit

  // read multiplexer; reserved bit is forced low in the config read
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      rcr_pkg::IDX_RMS_CONFIG: begin
        rd_byte = {cfg_r.rms_channel_select, 1'b0,
                   cfg_r.dc_removal_enable, cfg_r.window_sample_count};
      end
      rcr_pkg::IDX_RMS_LOW:    rd_byte = rms_value_r[7:0];
      rcr_pkg::IDX_RMS_HIGH:   rd_byte = rms_value_r[15:8];
      rcr_pkg::IDX_OUT0_MASK:  rd_byte = mask_r[0];
      rcr_pkg::IDX_OUT1_MASK:  rd_byte = mask_r[1];
      rcr_pkg::IDX_OUT2_MASK:  rd_byte = mask_r[2];
      rcr_pkg::IDX_OUT3_MASK:  rd_byte = mask_r[3];
      rcr_pkg::IDX_CH7_HIGH:   rd_byte = ch7_high_r;
      rcr_pkg::IDX_IRQ_STATUS: rd_byte = irq_stat_r;
      rcr_pkg::IDX_IRQ_MASK:   rd_byte = irq_mask_r;
      default:                 rd_byte = 8'h00;              // unmapped
    endcase
  end

  // ====================
  // apb answer: zero wait states, all outputs registered
  // ====================
  // ready rises in the first access cycle; read data is captured at setup
  // so it cannot shift while the master samples it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~(in_range & rcr_hit(idx));
      if (setup && in_range) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end else if (setup) begin
        prdata_r <= 32'h0000_0000;  // unmapped reads zero
      end
    end
  end

  // ====================
  // rms configuration register
  // ====================
  // a write also restarts the window count, see the counter below
  logic cfg_wr;
  assign cfg_wr = wr_en && in_range && (idx == rcr_pkg::IDX_RMS_CONFIG);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= rcr_pkg::RST_RMS_CONFIG;
    end else if (cfg_wr) begin
      cfg_r.rms_channel_select  <= pwdata[rcr_pkg::CFG_CHAN_LSB +: 4];
      cfg_r.rsvd                <= 1'b0;
      cfg_r.dc_removal_enable   <= pwdata[rcr_pkg::CFG_DC_BIT];
      cfg_r.window_sample_count <= pwdata[rcr_pkg::CFG_SAMP_LSB +: 2];
    end
  end

  // ====================
  // trigger mask registers
  // ====================
  // mask indices are spaced by two; the gaps are unmapped
  function automatic logic [7:0] rcr_mask_idx(input int unsigned n);
    logic [7:0] r;
    r = rcr_pkg::IDX_OUT0_MASK;
    unique case (n)
      0: r = rcr_pkg::IDX_OUT0_MASK;
      1: r = rcr_pkg::IDX_OUT1_MASK;
      2: r = rcr_pkg::IDX_OUT2_MASK;
      3: r = rcr_pkg::IDX_OUT3_MASK;
      default: r = rcr_pkg::IDX_OUT0_MASK;
    endcase
    return r;
  endfunction : rcr_mask_idx

  // per-output reset values differ, so each is chosen by number
  function automatic logic [7:0] rcr_mask_rst(input int unsigned n);
    logic [7:0] r;
    r = rcr_pkg::RST_OUT0_MASK;
    unique case (n)
      0: r = rcr_pkg::RST_OUT0_MASK;
      1: r = rcr_pkg::RST_OUT1_MASK;
      2: r = rcr_pkg::RST_OUT2_MASK;
      3: r = rcr_pkg::RST_OUT3_MASK;
      default: r = rcr_pkg::RST_OUT0_MASK;
    endcase
    return r;
  endfunction : rcr_mask_rst

  for (genvar g = 0; g < rcr_pkg::NUM_OUT; g++) begin : g_mask
    // plain read/write byte
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mask_r[g] <= rcr_mask_rst(g);
      end else if (wr_en && in_range && (idx == rcr_mask_idx(g))) begin
        mask_r[g] <= pwdata[7:0];
      end
    end
  end

  // ====================
  // event-based output triggers
  // ====================
  // an output triggers when any alert of an enabled channel is high;
  // only the rising edge of that condition is reported, so a flag held
  // high does not retrigger every cycle
  logic [3:0] trig_now;
  always_comb begin
    for (int i = 0; i < rcr_pkg::NUM_OUT; i++) begin
      trig_now[i] = |(alert_flags & mask_r[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_r  <= 4'h0;
      out_update_r <= 4'h0;
    end else begin
      trig_prev_r  <= trig_now;
      out_update_r <= trig_now & ~trig_prev_r;
    end
  end

  // ====================
  // rms window counter and result latch
  // ====================
  // counts conversions of the selected channel; at the last sample of the
  // window the engine's value is latched as one 16-bit word so both bytes
  // always belong to the same window
  logic        sel_hit;    // conversion belongs to the rms channel
  logic        win_last;   // this sample closes the window
  logic [16:0] win_len;    // samples in the window

  assign win_len  = rcr_pkg::rcr_win_len(cfg_r.window_sample_count);
  assign sel_hit  = conv_in.valid && (conv_in.chan == cfg_r.rms_channel_select);
  assign win_last = sel_hit && (win_cnt_r == win_len - 17'd1);

  // restart on a config write so a new channel or length gets a full window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_r <= 17'd0;
    end else if (cfg_wr || win_last) begin
      win_cnt_r <= 17'd0;
    end else if (sel_hit) begin
      win_cnt_r <= win_cnt_r + 17'd1;
    end
  end

  // result is never written from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rms_value_r <= rcr_pkg::RST_RMS_VALUE;
      done_r      <= 1'b0;
    end else begin
      done_r <= win_last & ~cfg_wr;
      if (win_last && !cfg_wr) begin
        rms_value_r <= rms_engine_value;
      end
    end
  end

  // ====================
  // channel 7 last result, msb-aligned byte
  // ====================
  logic ch7_hit;
  assign ch7_hit = conv_in.valid && (conv_in.chan == rcr_pkg::CH7_ID);

  // loaded only from the conversion stream; bus writes do not reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch7_high_r <= rcr_pkg::RST_CH7_HIGH;
    end else if (ch7_hit) begin
      ch7_high_r <= conv_in.data[rcr_pkg::CONV_MSB_LSB +: 8];
    end
  end

  // ====================
  // interrupts
  // ====================
  // a status read clears only the bits it returned; anything set after the
  // snapshot survives, and a set in the clearing cycle wins
  logic [7:0] st_set;
  logic [7:0] st_clr;
  logic       stat_rd;

  assign stat_rd = rd_done && in_range && (idx == rcr_pkg::IDX_IRQ_STATUS);
  assign st_clr  = stat_rd ? prdata_r[7:0] : 8'h00;

  always_comb begin
    st_set = 8'h00;
    st_set[rcr_pkg::ST_RMS_DONE] = win_last & ~cfg_wr;
    st_set[rcr_pkg::ST_CH7_NEW]  = ch7_hit;
    st_set[rcr_pkg::ST_OUT_LSB +: 4] = trig_now & ~trig_prev_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= rcr_pkg::RST_IRQ_STAT;
    end else begin
      irq_stat_r <= (irq_stat_r & ~st_clr) | st_set;
    end
  end

  // mask register, plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= rcr_pkg::RST_IRQ_MASK;
    end else if (wr_en && in_range && (idx == rcr_pkg::IDX_IRQ_MASK)) begin
      irq_mask_r <= pwdata[7:0];
    end
  end

  // level output, one cycle behind the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ====================
  // outputs
  // ====================
  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign rms_config         = cfg_r;
  assign rms_window_done = done_r;
  assign out_update      = out_update_r;
  assign irq             = irq_r;

endmodule : rcr_regs

/* File: rcr_regs_sva.sv */
// concurrent checks on the ports of the rms config and trigger mask register bank
// assumes the apb master of the bench and one pclk domain; the window count is mirrored here
`timescale 1ns/10ps

module rcr_regs_sva (
  input wire logic          pclk,             // bus clock
  input wire logic          presetn,          // async reset, active low
  input wire logic          psel,             // apb select
  input wire logic          penable,          // apb access phase
  input wire logic          pwrite,           // apb direction
  input wire logic [11:0]   paddr,            // apb byte address
  input wire logic [31:0]   pwdata,           // apb write data
  input wire logic [3:0]    pstrb,            // apb byte strobes
  input wire logic [31:0]   prdata,           // apb read data
  input wire logic          pready,           // apb ready
  input wire logic          pslverr,          // apb error
  input rcr_pkg::rcr_conv_s conv_in,          // conversion stream
  input wire logic [15:0]   rms_engine_value, // running rms estimate
  input wire logic [7:0]    alert_flags,      // per-channel alerts
  input rcr_pkg::rcr_cfg_s  rms_config,          // config to rms engine
  input wire logic          rms_window_done,  // window pulse
  input wire logic [3:0]    out_update,       // output triggers
  input wire logic          irq               // level interrupt
);
  // ====================
  // helper logic: mirrored window counter and latched result
  // ====================
  logic [16:0] win_cnt_r; // matching samples in the current window
  logic [15:0] rms_lat_r; // result expected at the two result bytes
  logic [16:0] win_len;   // window length for the current code
  logic        cfg_wr;    // config write taking effect at this edge
  logic        hit;       // sample of the selected channel
  logic        end_hit;   // last sample of a window
  logic [7:0]  lat_lo;    // expected low byte
  logic [7:0]  lat_hi;    // expected high byte
  assign cfg_wr  = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h300;
  assign hit     = conv_in.valid && conv_in.chan == rms_config.rms_channel_select;
  assign win_len = 17'h00400 << (2 * rms_config.window_sample_count); // 1024 times four per code step
  assign end_hit = hit && !cfg_wr && win_cnt_r == win_len - 17'h00001;
  assign lat_lo  = rms_lat_r[7:0];
  assign lat_hi  = rms_lat_r[15:8];
  // a config write restarts the count, and a sample in that cycle is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) win_cnt_r <= '0;
    else if (cfg_wr || end_hit) win_cnt_r <= '0;
    else if (hit) win_cnt_r <= win_cnt_r + 17'h00001;
  end
  // latch of the engine value at the end of each window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rms_lat_r <= 16'h0000;
    else if (end_hit) rms_lat_r <= rms_engine_value;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_setup(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  // ====================
  // assertions
  // ====================
  cfg_rsvd_zero_a: assert property (rms_config.rsvd == 1'b0)
    else $error("reserved config bit is set");
  cfg_write_a: assert property (cfg_wr |=> rms_config == {$past(pwdata[7:4]), 1'b0, $past(pwdata[2:0])})
    else $error("config fields differ from written value");
  cfg_hold_a: assert property (!cfg_wr |=> $stable(rms_config))
    else $error("config changed without a write");
  win_end_a: assert property (end_hit |=> rms_window_done)
    else $error("window done missing after last sample");
  win_only_a: assert property (rms_window_done |-> $past(end_hit))
    else $error("window done without a full window");
  rms_low_read_a: assert property (rd_setup(12'h304) |=> pready && prdata == {24'h000000, $past(lat_lo)})
    else $error("rms low byte read mismatch");
  rms_high_read_a: assert property (rd_setup(12'h308) |=> pready && prdata == {24'h000000, $past(lat_hi)})
    else $error("rms high byte read mismatch");
  upd_cause_a: assert property (out_update != 4'h0 |-> $past(alert_flags) != 8'h00)
    else $error("output update without any alert");
  upd_pulse_a: assert property (out_update != 4'h0 |=> (out_update & $past(out_update)) == 4'h0)
    else $error("output update longer than one cycle");
  misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr)
    else $error("misaligned access not refused");
endmodule : rcr_regs_sva

bind rcr_regs rcr_regs_sva i_rcr_regs_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conv_in(conv_in), .rms_engine_value(rms_engine_value), .alert_flags(alert_flags),
  .rms_config(rms_config), .rms_window_done(rms_window_done), .out_update(out_update), .irq(irq));

/* File: rcr_conv_src.sv */
// conversion source model: sends a burst of back-to-back samples of one channel
// assumes start is raised for one cycle only while busy is low
`timescale 1ns/10ps

module rcr_conv_src (
  input wire logic          pclk,     // bus clock
  input wire logic          presetn,  // async reset, active low
  input wire logic          start,    // begin a burst
  input wire logic [16:0]   count,    // samples in the burst
  input wire logic [3:0]    chan,     // channel of the burst
  input wire logic [11:0]   data,     // result carried by each sample
  output rcr_pkg::rcr_conv_s conv_out, // stream into the register bank
  output logic              busy      // burst in progress
);
  logic [16:0] left_r; // samples still to send
  assign busy = left_r != 17'h00000;
  // idle cycles carry inverted fields so stale values never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r   <= 17'h00000;
      conv_out <= '0;
    end else if (start) begin
      left_r         <= count;
      conv_out.valid <= 1'b0;
    end else if (busy) begin
      left_r   <= left_r - 17'h00001;
      conv_out <= {1'b1, chan, data};
    end else begin
      conv_out <= {1'b0, ~conv_out.chan, ~conv_out.data};
    end
  end
endmodule : rcr_conv_src

/* File: tb_rcr_regs.sv */
// self-checking bench for the rms config and trigger mask register bank
// assumes zero-wait apb answers are awaited, not counted on
`timescale 1ns/10ps

module tb_rcr_regs;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rms_window_done;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         out_update, upd_seen;
  logic [15:0]        rms_engine_value;
  logic [7:0]         alert_flags, rd_v;
  logic               err_v, done_seen, seen_clr, src_start, src_busy;
  logic [16:0]        src_count;
  logic [3:0]         src_chan;
  logic [1:0]         lo_v;
  logic [11:0]        src_data;
  rcr_pkg::rcr_conv_s conv_in;
  rcr_pkg::rcr_cfg_s  rms_config;
  int                 fail_count, total_checks;
  // register index and reset value tables
  logic [7:0] idx_t [8] = '{8'hC0, 8'hC3, 8'hC5, 8'hC7, 8'hC9, 8'hC1, 8'hC2, 8'hAF};
  logic [7:0] rst_t [8] = '{8'h00, 8'h02, 8'h01, 8'h08, 8'h04, 8'h00, 8'h00, 8'h00};

  rcr_regs i_rcr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_in(conv_in), .rms_engine_value(rms_engine_value), .alert_flags(alert_flags), .rms_config(rms_config),
    .rms_window_done(rms_window_done), .out_update(out_update), .irq(irq));
  rcr_conv_src i_rcr_conv_src (.pclk(pclk), .presetn(presetn), .start(src_start), .count(src_count),
    .chan(src_chan), .data(src_data), .conv_out(conv_in), .busy(src_busy));

  // ====================
  // clock, sticky pulse monitor, watchdog
  // ====================
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // catch one-cycle pulses so tests need not hit their cycle
  always @(posedge pclk) begin
    upd_seen  <= (!presetn || seen_clr) ? 4'h0 : upd_seen | out_update;
    done_seen <= (!presetn || seen_clr) ? 1'b0 : done_seen | rms_window_done;
  end
  initial begin
    #400000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  // ====================
  // tasks
  // ====================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : chk_bit
  // one apb transfer, held until pready is seen high; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, lo_v};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v  = prdata[7:0];
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // alert level held for three cycles, then dropped
  task automatic pulse(input logic [7:0] v);
    seen_clr <= 1'b1;
    @(posedge pclk);
    seen_clr    <= 1'b0;
    alert_flags <= v;
    repeat (3) @(posedge pclk);
    alert_flags <= 8'h00;
    repeat (2) @(posedge pclk);
  endtask : pulse
  task automatic send(input logic [3:0] ch, input logic [11:0] d, input logic [16:0] n);
    src_chan  <= ch;
    src_data  <= d;
    src_count <= n;
    src_start <= 1'b1;
    @(posedge pclk);
    src_start <= 1'b0;
    @(posedge pclk);
    for (int k = 0; k < 70000 && src_busy !== 1'b0; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : send
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ====================
  // test sequence
  // ====================
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rms_engine_value, alert_flags, seen_clr, src_start, src_count, src_chan, src_data, lo_v} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, idx_t[i], 8'h00);
      chk(rd_v, rst_t[i]);
    end
    $display("test reset values ended");
    apb(1'b1, 8'hC0, 8'hFF);
    apb(1'b0, 8'hC0, 8'h00);
    chk(rd_v, 8'hF7);
    chk(rms_config, 8'hF7);
    for (int i = 5; i < 8; i++) begin
      apb(1'b1, idx_t[i], 8'hFF);
      apb(1'b0, idx_t[i], 8'h00);
      chk(rd_v, 8'h00);
    end
    apb(1'b0, 8'hC4, 8'h00);
    chk_bit(err_v, 1'b1);
    lo_v = 2'b10;
    apb(1'b0, 8'hC0, 8'h00);
    chk_bit(err_v, 1'b1);
    chk(rd_v, 8'h00);
    lo_v = 2'b00;
    $display("test config and read-only ended");
    apb(1'b1, 8'hE1, 8'h3C);
    for (int o = 0; o < 4; o++) begin
      for (int b = 0; b < 8; b++) begin
        apb(1'b1, idx_t[o + 1], 8'h01 << b);
        pulse(~(8'h01 << b));
        chk_bit(upd_seen[o], 1'b0);
        pulse(8'h01 << b);
        chk_bit(upd_seen[o], 1'b1);
      end
    end
    chk_bit(irq, 1'b1);
    apb(1'b0, 8'hE0, 8'h00);
    chk(rd_v & 8'h3C, 8'h3C);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b1, 8'hE1, 8'h00);
    pulse(8'h80);
    chk_bit(irq, 1'b0);
    $display("test alert triggers ended");
    send(4'h7, 12'hABC, 17'h00001);
    apb(1'b0, 8'hAF, 8'h00);
    chk(rd_v, 8'hAB);
    send(4'h6, 12'h123, 17'h00001);
    apb(1'b0, 8'hAF, 8'h00);
    chk(rd_v, 8'hAB);
    $display("test channel 7 byte ended");
    for (int c = 0; c < 2; c++) begin
      seen_clr <= 1'b1;
      apb(1'b1, 8'hC0, 8'(8'h30 | (c << 2) | c));
      seen_clr <= 1'b0;
      rms_engine_value <= 16'(16'h1234 + c * 16'h4837);
      send(4'h3, 12'h055, (17'h00400 << (2 * c)) - 17'h00001);
      chk_bit(done_seen, 1'b0);
      send(4'h3, 12'h055, 17'h00001);
      chk_bit(done_seen, 1'b1);
      apb(1'b0, 8'hC1, 8'h00);
      chk(rd_v, c ? 8'h6B : 8'h34);
      apb(1'b0, 8'hC2, 8'h00);
      chk(rd_v, c ? 8'h5A : 8'h12);
    end
    $display("test rms window ended");
    finish_test();
  end
endmodule : tb_rcr_regs
